// ===== hdl/pc_stack_indirect_unit.sv
// program counter, return stack and indirect pointer unit of the core
// assumes one instruction clock; decoder issues one op per cycle and
// a memory fabric answers indirect data accesses combinationally
`timescale 1ns/100ps
`default_nettype none
`include "pcstk_defs.svh"
// Contract
// [RULE1] 15-bit pc, low byte readable, upper from latch
// [RULE2] any reset clears the pc
// [RULE3] low byte write copies latch into pc upper
// [RULE4] call loads operand and latch bits 6:3
// [RULE5] call via work uses work and latch
// [RULE6] work branch loads pc plus one plus work
// [RULE7] relative branch loads pc plus one plus offset
// [RULE8] sixteen by fifteen-bit dedicated return stack
// [RULE9] calls and interrupts push, returns pop, latch untouched; the code reloads the latch from its shadow on interrupt return
// [RULE10] fault reset off makes stack circular
// [RULE11] overflow and underflow flags always set
// [RULE12] software reads and writes pointer and top entry
// [RULE13] push increments then writes; pop reads then decrements
// [RULE14] empty pointer is 0x1F, first push gives 0x00
// [RULE15] fault reset on resets device and records flag
// [RULE16] pointer at indirect port reads zero, write dropped
// [RULE17] pointer is high byte joined with low byte
// [RULE18] 0x000 to 0xFFF maps onto data addresses
// [RULE19] linear region strings banks' 80-byte ram blocks
// [RULE20] unimplemented linear locations read 0x00
// [RULE21] top bit addresses flash low byte, read only
// [RULE22] flash access through port costs one extra cycle
// [RULE23] linear bank is quotient, offset 0x20 plus remainder
// [RULE24] interrupt entry saves context, interrupt return restores
module pc_stack_indirect_unit (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire pcstk_pkg::pc_req_s pc_req_in,
  input wire logic [7:0] work_in,
  input wire logic [7:0] low_wdata_in,
  input wire logic fault_reset_en_in,
  input wire pcstk_pkg::core_ctx_s core_ctx_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire pcstk_pkg::ind_req_s ind_req_in,
  output logic [7:0] ind_rdata_out,
  output logic ind_stall_out,
  output logic [11:0] data_addr_out,
  output logic data_rd_out,
  output logic data_wr_out,
  output logic [7:0] data_wdata_out,
  input wire logic [7:0] data_rdata_in,
  output logic [14:0] flash_addr_out,
  input wire logic [13:0] flash_rdata_in,
  output logic [14:0] pc_out,
  output logic stack_reset_out,
  output pcstk_pkg::core_ctx_s ctx_restore_out,
  output logic ctx_restore_valid_out
);
  import pcstk_pkg::*;

  logic [14:0] pc_q, pc_d; // program counter
  logic [6:0] latch_q; // pc_high_latch
  logic [14:0] stack_q [`STK_DEPTH]; // flip-flop return stack
  logic [4:0] sp_q; // return_stack_pointer
  logic ovf_q, unf_q; // stack flags in fault register
  logic fault_q; // stack fault reset pulse
  logic [7:0] p0l_q, p0h_q, p1l_q, p1h_q; // file pointers
  core_ctx_s ctx_q; // shadow of core context
  logic [6:0] latch_ctx_q;
  logic [7:0] s0l_q, s0h_q, s1l_q, s1h_q; // pointer shadows
  logic [7:0] rdata_q, ind_rdata_q;
  logic flash_wait_q; // extra cycle done for a flash access
  logic restore_q;

  // next-instruction address, used by both branch forms
  wire [14:0] pc_inc = pc_q + 15'h0001;
  wire [14:0] rel_ofs = {{6{pc_req_in.operand[8]}},
                         pc_req_in.operand[8:0]};
  wire is_push = (pc_req_in.op == OP_CALL) ||
                 (pc_req_in.op == OP_CALL_WORK) ||
                 (pc_req_in.op == OP_INT_ENTRY); // see [RULE9]
  wire is_pop = (pc_req_in.op == OP_RETURN) ||
                (pc_req_in.op == OP_RETURN_LIT) ||
                (pc_req_in.op == OP_RETURN_INT); // see [RULE9]
  wire [4:0] sp_inc = sp_q + 5'h01; // see [RULE13]
  wire [4:0] sp_dec = sp_q - 5'h01;
  // full when pointer is 0x0F, empty when it is 0x1F
  wire push_ovf = is_push && (sp_q == `SP_FULL); // see [RULE11]
  wire pop_unf = is_pop && (sp_q == `SP_EMPTY); // see [RULE14]
  // circular wrap uses low four bits only
  wire [3:0] push_idx = sp_inc[3:0]; // see [RULE10]
  wire [3:0] tos_idx = sp_q[3:0];
  wire [14:0] tos_val = stack_q[tos_idx]; // see [RULE12]

  // register port decode
  wire w_pcl = reg_wr_in && (reg_addr_in == `OFS_PC_LOW);
  wire w_lat = reg_wr_in && (reg_addr_in == `OFS_PC_LATCH);
  wire w_sp = reg_wr_in && (reg_addr_in == `OFS_SP);
  wire w_stack_top_low = reg_wr_in && (reg_addr_in == `OFS_TOS_LOW);
  wire w_stack_top_high = reg_wr_in && (reg_addr_in == `OFS_TOS_HIGH);
  wire w_flt = reg_wr_in && (reg_addr_in == `OFS_FAULT);

  // indirect pointer selection and region decode
  wire [15:0] fptr = ind_req_in.sel ? {p1h_q, p1l_q} : {p0h_q, p0l_q};
  // see [RULE17]
  wire in_flash = fptr[`FLASH_BIT]; // see [RULE21]
  wire in_trad = !in_flash && (fptr <= `TRAD_TOP); // see [RULE18]
  wire in_lin = (fptr >= `LIN_BASE) && (fptr <= `LIN_TOP);
  wire [15:0] lin_rel = fptr - `LIN_BASE;
  wire [15:0] lin_bank16 = lin_rel / `LIN_BLOCK; // see [RULE23]
  wire [15:0] lin_rem16 = lin_rel % `LIN_BLOCK;
  wire [11:0] lin_addr = {lin_bank16[4:0],
                          `LIN_OFS + lin_rem16[6:0]}; // see [RULE19]
  wire [11:0] trad_addr = fptr[11:0];
  // a pointer aimed at either indirect port is a dead access
  wire self_hit = in_trad && (trad_addr[6:0] <= `IND1_ADDR);
  // see [RULE16]
  wire ind_act = ind_req_in.rd || ind_req_in.wr;
  wire mapped = (in_trad || in_lin) && !self_hit; // see [RULE20]

  assign data_addr_out = in_lin ? lin_addr : trad_addr;
  assign data_rd_out = ind_req_in.rd && mapped;
  assign data_wr_out = ind_req_in.wr && mapped; // flash writes dropped
  assign data_wdata_out = ind_req_in.wdata;
  assign flash_addr_out = fptr[14:0];
  // stall the core one cycle on any flash access
  assign ind_stall_out = ind_act && in_flash && !flash_wait_q;
  // see [RULE22]
  assign ind_rdata_out = ind_rdata_q;
  assign reg_rdata_out = rdata_q;
  assign pc_out = pc_q;
  assign stack_reset_out = fault_q;
  assign ctx_restore_out = ctx_q;
  assign ctx_restore_valid_out = restore_q;

  // pc next value by operation; register write of low byte too
  always_comb begin
    pc_d = pc_q;
    case (pc_req_in.op)
      OP_INC: pc_d = pc_inc;
      OP_WRITE_LOW: pc_d = {latch_q, low_wdata_in}; // see [RULE3]
      OP_CALL: pc_d = {latch_q[6:3], pc_req_in.operand}; // see [RULE4]
      OP_CALL_WORK: pc_d = {latch_q, work_in}; // see [RULE5]
      OP_BRANCH_WORK: pc_d = pc_inc + {7'h00, work_in}; // see [RULE6]
      OP_BRANCH_REL: pc_d = pc_inc + rel_ofs; // see [RULE7]
      OP_RETURN, OP_RETURN_LIT, OP_RETURN_INT: pc_d = tos_val;
      OP_INT_ENTRY: pc_d = `INT_VEC; // interrupt vector
      default: pc_d = pc_q;
    endcase
    if (w_pcl) begin
      pc_d = {latch_q, reg_wdata_in}; // see [RULE3]
    end
  end

  // program counter and latch; of the stack ops only interrupt return reloads the latch
  always_ff @(posedge clk_in) begin
    if (reset_in || fault_q) begin
      pc_q <= 15'h0000; // see [RULE2]
      latch_q <= 7'h00;
    end else begin
      pc_q <= pc_d; // see [RULE1]
      if (w_lat) begin
        latch_q <= reg_wdata_in[6:0]; // see [RULE9]
      end else if (pc_req_in.op == OP_RETURN_INT) begin
        latch_q <= latch_ctx_q; // see [RULE24]
      end
    end
  end

  // return stack storage, not in program or data space
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < `STK_DEPTH; i++) begin
        stack_q[i] <= 15'h0000; // see [RULE8]
      end
    end else if (is_push) begin
      stack_q[push_idx] <= pc_inc; // see [RULE13]
    end else if (w_stack_top_low) begin
      stack_q[tos_idx][7:0] <= reg_wdata_in; // see [RULE12]
    end else if (w_stack_top_high) begin
      stack_q[tos_idx][14:8] <= reg_wdata_in[6:0];
    end
  end

  // stack pointer and fault reset
  always_ff @(posedge clk_in) begin
    if (reset_in || fault_q) begin
      sp_q <= `SP_EMPTY; // see [RULE14]
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_reset_en_in && (push_ovf || pop_unf);
      // see [RULE15]
      if (is_push) begin
        sp_q <= push_ovf ? 5'h00 : sp_inc; // see [RULE10]
      end else if (is_pop) begin
        sp_q <= (sp_q == 5'h00) ? `SP_EMPTY :
                (pop_unf ? `SP_FULL : sp_dec); // see [RULE13]
      end else if (w_sp) begin
        sp_q <= reg_wdata_in[4:0]; // see [RULE12]
      end
    end
  end

  // flags survive the stack reset; set wins over software clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      ovf_q <= push_ovf || (ovf_q && !(w_flt &&
               !reg_wdata_in[`FLT_OVF_BIT])); // see [RULE11]
      unf_q <= pop_unf || (unf_q && !(w_flt &&
               !reg_wdata_in[`FLT_UNF_BIT]));
    end
  end

  // file pointers written by software
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      p0l_q <= 8'h00;
      p0h_q <= 8'h00;
      p1l_q <= 8'h00;
      p1h_q <= 8'h00;
    end else if (pc_req_in.op == OP_RETURN_INT) begin
      p0l_q <= s0l_q; // see [RULE24]
      p0h_q <= s0h_q;
      p1l_q <= s1l_q;
      p1h_q <= s1h_q;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `OFS_PTR0_LOW) p0l_q <= reg_wdata_in;
      if (reg_addr_in == `OFS_PTR0_HIGH) p0h_q <= reg_wdata_in;
      if (reg_addr_in == `OFS_PTR1_LOW) p1l_q <= reg_wdata_in;
      if (reg_addr_in == `OFS_PTR1_HIGH) p1h_q <= reg_wdata_in;
    end
  end

  // context shadows: captured on interrupt entry, also writable
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctx_q <= '0;
      latch_ctx_q <= 7'h00;
      s0l_q <= 8'h00;
      s0h_q <= 8'h00;
      s1l_q <= 8'h00;
      s1h_q <= 8'h00;
    end else if (pc_req_in.op == OP_INT_ENTRY) begin
      ctx_q <= core_ctx_in; // see [RULE24]
      latch_ctx_q <= latch_q;
      s0l_q <= p0l_q;
      s0h_q <= p0h_q;
      s1l_q <= p1l_q;
      s1h_q <= p1h_q;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `OFS_FLAGS_CTX) ctx_q.flags <= reg_wdata_in[2:0];
      if (reg_addr_in == `OFS_WORK_CTX) ctx_q.work <= reg_wdata_in;
      if (reg_addr_in == `OFS_BANK_CTX) ctx_q.bank <= reg_wdata_in[4:0];
      if (reg_addr_in == `OFS_LATCH_CTX) latch_ctx_q <= reg_wdata_in[6:0];
      if (reg_addr_in == `OFS_P0L_CTX) s0l_q <= reg_wdata_in;
      if (reg_addr_in == `OFS_P0H_CTX) s0h_q <= reg_wdata_in;
      if (reg_addr_in == `OFS_P1L_CTX) s1l_q <= reg_wdata_in;
      if (reg_addr_in == `OFS_P1H_CTX) s1h_q <= reg_wdata_in;
    end
  end

  // register read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr_in == `OFS_PC_LOW) rd_mux = pc_q[7:0];
    else if (reg_addr_in == `OFS_PC_LATCH) rd_mux = {1'b0, latch_q};
    else if (reg_addr_in == `OFS_SP) rd_mux = {3'h0, sp_q};
    else if (reg_addr_in == `OFS_TOS_LOW) rd_mux = tos_val[7:0];
    else if (reg_addr_in == `OFS_TOS_HIGH) rd_mux = {1'b0, tos_val[14:8]};
    else if (reg_addr_in == `OFS_FAULT) rd_mux = {ovf_q, unf_q, 6'h00};
    else if (reg_addr_in == `OFS_PTR0_LOW) rd_mux = p0l_q;
    else if (reg_addr_in == `OFS_PTR0_HIGH) rd_mux = p0h_q;
    else if (reg_addr_in == `OFS_PTR1_LOW) rd_mux = p1l_q;
    else if (reg_addr_in == `OFS_PTR1_HIGH) rd_mux = p1h_q;
    else if (reg_addr_in == `OFS_FLAGS_CTX) rd_mux = {5'h00, ctx_q.flags};
    else if (reg_addr_in == `OFS_WORK_CTX) rd_mux = ctx_q.work;
    else if (reg_addr_in == `OFS_BANK_CTX) rd_mux = {3'h0, ctx_q.bank};
    else if (reg_addr_in == `OFS_LATCH_CTX) rd_mux = {1'b0, latch_ctx_q};
    else if (reg_addr_in == `OFS_P0L_CTX) rd_mux = s0l_q;
    else if (reg_addr_in == `OFS_P0H_CTX) rd_mux = s0h_q;
    else if (reg_addr_in == `OFS_P1L_CTX) rd_mux = s1l_q;
    else if (reg_addr_in == `OFS_P1H_CTX) rd_mux = s1h_q;
  end

  // indirect read value: dead or unimplemented locations give zero
  wire [7:0] ind_val = in_flash ? flash_rdata_in[7:0] :
                       (mapped ? data_rdata_in : 8'h00); // see [RULE16]

  // registered read data, flash wait flag and restore pulse
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
      ind_rdata_q <= 8'h00;
      flash_wait_q <= 1'b0;
      restore_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : 8'h00;
      if (ind_req_in.rd) ind_rdata_q <= ind_val; // see [RULE21]
      flash_wait_q <= ind_stall_out; // see [RULE22]
      restore_q <= (pc_req_in.op == OP_RETURN_INT);
    end
  end
endmodule
`default_nettype wire

// ===== shared/pcstk_defs.svh
// constants for the program counter, return stack and indirect port unit
// assumes inclusion by bare name from the package and the design file
`ifndef PCSTK_DEFS_SVH
`define PCSTK_DEFS_SVH
`define PC_W 15
`define STK_DEPTH 16
`define SP_W 5
`define SP_EMPTY 5'h1F
`define SP_FULL 5'h0F
`define INT_VEC 15'h0004
`define FA_W 16
// register offsets on the plain register port
`define OFS_FLAGS_CTX 12'hFE4
`define OFS_WORK_CTX 12'hFE5
`define OFS_BANK_CTX 12'hFE6
`define OFS_LATCH_CTX 12'hFE7
`define OFS_P0L_CTX 12'hFE8
`define OFS_P0H_CTX 12'hFE9
`define OFS_P1L_CTX 12'hFEA
`define OFS_P1H_CTX 12'hFEB
`define OFS_SP 12'hFED
`define OFS_TOS_LOW 12'hFEE
`define OFS_TOS_HIGH 12'hFEF
`define OFS_PC_LOW 12'hF02
`define OFS_PC_LATCH 12'hF0A
`define OFS_FAULT 12'hF16
`define OFS_PTR0_LOW 12'hF04
`define OFS_PTR0_HIGH 12'hF05
`define OFS_PTR1_LOW 12'hF06
`define OFS_PTR1_HIGH 12'hF07
`define OFS_IND0 12'hF00
`define OFS_IND1 12'hF01
// fault register bit positions
`define FLT_OVF_BIT 7
`define FLT_UNF_BIT 6
// address map of the pointer space
`define TRAD_TOP 16'h0FFF
`define LIN_BASE 16'h2000
`define LIN_TOP 16'h29AF
`define LIN_BLOCK 16'h0050
`define LIN_OFS 7'h20
`define FLASH_BIT 15
`define IND0_ADDR 7'h00
`define IND1_ADDR 7'h01
`endif

// ===== shared/pcstk_pkg.sv
// types shared by the program counter and return stack unit
// assumes pcstk_defs.svh is on the include path
`include "pcstk_defs.svh"
package pcstk_pkg;
  // control operation requested by the instruction decoder
  typedef enum logic [3:0] {
    OP_NONE, OP_INC, OP_WRITE_LOW, OP_CALL, OP_CALL_WORK, OP_BRANCH_WORK,
    OP_BRANCH_REL, OP_RETURN, OP_RETURN_LIT, OP_RETURN_INT, OP_INT_ENTRY
  } pc_op_e;
  // one decoder request with its operand
  typedef struct packed {
    pc_op_e op;
    logic [10:0] operand;
  } pc_req_s;
  // indirect access request from the core
  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } ind_req_s;
  // core context that interrupt entry copies
  typedef struct packed {
    logic [2:0] flags;
    logic [7:0] work;
    logic [4:0] bank;
  } core_ctx_s;
endpackage

// ===== test/pcstk_assertions.sv
// assertions for the pc, return stack and indirect unit
// assumes binding onto the unit; one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
`include "pcstk_defs.svh"
module pcstk_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire pcstk_pkg::pc_req_s pc_req_in,
  input wire logic [7:0] work_in,
  input wire logic [7:0] low_wdata_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic ind_stall_out,
  input wire logic [11:0] data_addr_out,
  input wire logic data_wr_out,
  input wire logic [14:0] pc_out,
  input wire logic stack_reset_out,
  input wire logic ctx_restore_valid_out
);
  import pcstk_pkg::*;
  logic [6:0] latch_q; // copy of the pc upper latch
  logic [6:0] latch_sh_q; // copy of its interrupt shadow
  wire [14:0] rel_w = {{6{pc_req_in.operand[8]}}, pc_req_in.operand[8:0]};
  wire lat_wr = reg_wr_in && (reg_addr_in == `OFS_PC_LATCH);
  wire lat_sh_wr = reg_wr_in && (reg_addr_in == `OFS_LATCH_CTX);
  // latch copy: software write wins over interrupt restore
  always_ff @(posedge clk_in) begin
    if (reset_in || stack_reset_out) begin
      latch_q <= 7'h00;
    end else if (lat_wr) begin
      latch_q <= reg_wdata_in[6:0];
    end else if (pc_req_in.op == OP_RETURN_INT) begin
      latch_q <= latch_sh_q;
    end
  end
  // shadow copy: interrupt entry wins over software write
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      latch_sh_q <= 7'h00;
    end else if (pc_req_in.op == OP_INT_ENTRY) begin
      latch_sh_q <= latch_q;
    end else if (lat_sh_wr) begin
      latch_sh_q <= reg_wdata_in[6:0];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_PC_CLEAR: assert property (
    $fell(reset_in) |-> pc_out == 15'h0000)
    else $error("pc not cleared by reset");
  AST_LOW_WRITE: assert property (
    pc_req_in.op == OP_WRITE_LOW |=>
    pc_out == {$past(latch_q), $past(low_wdata_in)})
    else $error("low write pc");
  AST_CALL: assert property (
    pc_req_in.op == OP_CALL |=>
    pc_out == {$past(latch_q[6:3]), $past(pc_req_in.operand)})
    else $error("call pc");
  AST_CALL_WORK: assert property (
    pc_req_in.op == OP_CALL_WORK |=>
    pc_out == {$past(latch_q), $past(work_in)})
    else $error("call via work pc");
  AST_BR_WORK: assert property (
    pc_req_in.op == OP_BRANCH_WORK |=>
    pc_out == 15'($past(pc_out) + 15'h1 + $past(work_in)))
    else $error("work branch");
  AST_BR_REL: assert property (
    pc_req_in.op == OP_BRANCH_REL |=>
    pc_out == 15'($past(pc_out) + 15'h1 + $past(rel_w)))
    else $error("rel branch");
  AST_WR_GUARD: assert property (
    data_wr_out |-> data_addr_out[6:1] != 6'h00)
    else $error("write reached an indirect port");
  AST_FLASH_RO: assert property (
    ind_stall_out |-> !data_wr_out)
    else $error("flash access wrote data");
  AST_STALL_ONE: assert property (
    ind_stall_out |=> !ind_stall_out)
    else $error("flash stall too long");
  AST_RD_IDLE: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  AST_FAULT_PULSE: assert property (
    stack_reset_out |=> !stack_reset_out)
    else $error("fault reset longer than a cycle");
  AST_CTX_VALID: assert property (
    pc_req_in.op == OP_RETURN_INT |=> ctx_restore_valid_out)
    else $error("no context restore");
  cover property (pc_req_in.op == OP_CALL);
  cover property (stack_reset_out);
  cover property (ind_stall_out);
  cover property (ctx_restore_valid_out);
endmodule
bind pc_stack_indirect_unit pcstk_chk i_chk (.clk_in, .reset_in, .pc_req_in,
  .work_in, .low_wdata_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .ind_stall_out, .data_addr_out, .data_wr_out, .pc_out,
  .stack_reset_out, .ctx_restore_valid_out);
`default_nettype wire

// ===== test/test_pc_stack_indirect_unit.sv
// self-checking bench for the pc, return stack and indirect unit
// assumes the unit alone, driven at its ports with a 50 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "pcstk_defs.svh"
`define CHK(nm, got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("wrong value %s exp %h got %h", nm, exp, got); end end
module test_pc_stack_indirect_unit;
  import pcstk_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  pc_req_s req = '{OP_NONE, 11'h000};
  logic [7:0] work = 8'h00, lowd = 8'h00, wdat = 8'h00, drd = 8'h5A;
  logic fen = 1'b0, wr = 1'b0, rd = 1'b0;
  core_ctx_s ctx = '{3'h5, 8'hC3, 5'h0A}; // saved on interrupt entry
  logic [11:0] addr = 12'h000;
  ind_req_s ind = '0;
  logic [13:0] frd = 14'h3ABC; // flash word; only low byte is visible
  logic [7:0] rdo, indo, dwdo, s_wd;
  logic stall, drdo, dwro, srst, ctxv, s_wr, s_rd, s_st, s_v;
  logic [11:0] daddr, s_addr;
  logic [14:0] faddr, pc, s_fa;
  core_ctx_s ctxo, s_ctx;
  int n_errors = 0, n_compared = 0, cycles = 0, n_srst = 0;
  pc_stack_indirect_unit i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .pc_req_in(req), .work_in(work), .low_wdata_in(lowd),
    .fault_reset_en_in(fen), .core_ctx_in(ctx), .reg_addr_in(addr),
    .reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdo),
    .ind_req_in(ind), .ind_rdata_out(indo), .ind_stall_out(stall),
    .data_addr_out(daddr), .data_rd_out(drdo), .data_wr_out(dwro),
    .data_wdata_out(dwdo), .data_rdata_in(drd), .flash_addr_out(faddr),
    .flash_rdata_in(frd), .pc_out(pc), .stack_reset_out(srst),
    .ctx_restore_out(ctxo), .ctx_restore_valid_out(ctxv));
  initial forever #10 clk_in = ~clk_in;
  // hang guard; the whole run needs about 150 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (srst === 1'b1) n_srst++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // each task starts just after a rising edge and ends on one
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e,
                        input string nm);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    `CHK(nm, rdo, e)
    @(posedge clk_in);
  endtask
  // unknown expectation skips the pc compare
  task automatic do_op(input pc_op_e o, input logic [10:0] a,
                       input logic [14:0] e);
    req <= '{o, a};
    @(posedge clk_in);
    req <= '{OP_NONE, 11'h000};
    @(negedge clk_in);
    s_v = ctxv;
    s_ctx = ctxo;
    if (!$isunknown(e)) `CHK("pc", pc, e)
    @(posedge clk_in);
  endtask
  task automatic ptr(input logic s, input logic [15:0] v);
    wr_reg(s ? `OFS_PTR1_LOW : `OFS_PTR0_LOW, v[7:0]);
    wr_reg(s ? `OFS_PTR1_HIGH : `OFS_PTR0_HIGH, v[15:8]);
  endtask
  // holds the request through the flash stall cycle
  // stall and data outputs are taken mid-cycle, never at the edge
  task automatic ind_acc(input logic s, input logic r, input logic w,
                         input logic [7:0] d);
    logic st;
    ind <= '{s, r, w, d};
    s_st = 1'b0;
    do begin
      @(negedge clk_in);
      st = (stall === 1'b1);
      s_st = s_st | st;
      {s_addr, s_rd, s_wr, s_fa, s_wd} = {daddr, drdo, dwro, faddr, dwdo};
      @(posedge clk_in);
    end while (st);
    ind <= '0;
    @(posedge clk_in);
  endtask
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
    `CHK("pc reset", pc, 15'h0000)
    @(posedge clk_in);
    rd_reg(`OFS_SP, 8'h1F, "sp empty");
    rd_reg(12'h123, 8'h00, "unmapped");
    fin("reset");
    wr_reg(`OFS_PC_LATCH, 8'h15);
    lowd <= 8'h34;
    do_op(OP_WRITE_LOW, 11'h000, 15'h1534);
    rd_reg(`OFS_PC_LOW, 8'h34, "pc low");
    work <= 8'hFF;
    do_op(OP_BRANCH_WORK, 11'h000, 15'h1634);
    do_op(OP_BRANCH_REL, 11'h1FE, 15'h1633);
    do_op(OP_CALL, 11'h7AB, 15'h17AB);
    rd_reg(`OFS_SP, 8'h00, "sp first push");
    rd_reg(`OFS_TOS_LOW, 8'h34, "tos low");
    rd_reg(`OFS_TOS_HIGH, 8'h16, "tos high");
    work <= 8'h9C;
    do_op(OP_CALL_WORK, 11'h000, 15'h159C);
    do_op(OP_RETURN, 11'h000, 15'h17AC);
    do_op(OP_RETURN_LIT, 11'h000, 15'h1634);
    rd_reg(`OFS_SP, 8'h1F, "sp emptied");
    rd_reg(`OFS_PC_LATCH, 8'h15, "latch kept");
    fin("pc loads");
    for (int i = 0; i < 17; i++) begin
      do_op(OP_CALL, 11'(i), {4'h2, 11'(i)});
    end
    rd_reg(`OFS_SP, 8'h00, "sp wrapped");
    rd_reg(`OFS_TOS_LOW, 8'h10, "overwritten low");
    rd_reg(`OFS_FAULT, 8'h80, "overflow flag");
    `CHK("no fault reset", n_srst, 0)
    wr_reg(`OFS_FAULT, 8'h00);
    wr_reg(`OFS_SP, 8'h1F);
    // entry 0x0F still holds the sixteenth return address
    do_op(OP_RETURN, 11'h000, 15'h100F);
    rd_reg(`OFS_SP, 8'h0F, "sp underflow");
    rd_reg(`OFS_FAULT, 8'h40, "underflow flag");
    fin("circular stack");
    wr_reg(`OFS_FAULT, 8'h00);
    fen <= 1'b1;
    wr_reg(`OFS_SP, 8'h1F);
    do_op(OP_RETURN, 11'h000, 15'h100F);
    repeat (3) @(posedge clk_in);
    fen <= 1'b0;
    `CHK("fault resets", n_srst, 1)
    `CHK("pc after fault", pc, 15'h0000)
    rd_reg(`OFS_SP, 8'h1F, "sp after fault");
    rd_reg(`OFS_FAULT, 8'h40, "fault recorded");
    fin("fault reset");
    wr_reg(`OFS_SP, 8'h03);
    wr_reg(`OFS_TOS_LOW, 8'hA5);
    wr_reg(`OFS_TOS_HIGH, 8'h2B);
    rd_reg(`OFS_TOS_LOW, 8'hA5, "sw tos low");
    rd_reg(`OFS_TOS_HIGH, 8'h2B, "sw tos high");
    do_op(OP_INT_ENTRY, 11'h000, `INT_VEC);
    rd_reg(`OFS_WORK_CTX, 8'hC3, "work copy");
    do_op(OP_RETURN_INT, 11'h000, 15'h0001);
    `CHK("restore", {s_v, s_ctx}, {1'b1, ctx})
    do_op(OP_INC, 11'h000, 15'h0002);
    fin("software stack and interrupt");
    ptr(1'b0, 16'h0123);
    ind_acc(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK("trad addr", s_addr, 12'h123)
    `CHK("trad data", {s_rd, indo}, {1'b1, 8'h5A})
    ptr(1'b1, 16'h2055);
    ind_acc(1'b1, 1'b0, 1'b1, 8'h77);
    `CHK("linear addr", s_addr, 12'h0A5)
    `CHK("linear write", {s_wr, s_wd}, {1'b1, 8'h77})
    ptr(1'b0, 16'h0F80);
    ind_acc(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK("port read", {s_rd, indo}, {1'b0, 8'h00})
    ind_acc(1'b0, 1'b0, 1'b1, 8'h99);
    `CHK("port write", s_wr, 1'b0)
    ptr(1'b0, 16'h8123);
    ind_acc(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK("flash addr", s_fa, 15'h0123)
    `CHK("flash read", indo, 8'hBC)
    `CHK("flash stall", s_st, 1'b1)
    ind_acc(1'b0, 1'b0, 1'b1, 8'h55);
    `CHK("flash write", s_wr, 1'b0)
    // previous read left a non-zero value, so a stale result shows
    ptr(1'b0, 16'h29B0);
    ind_acc(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK("unimplemented", {s_rd, indo}, {1'b0, 8'h00})
    fin("indirect");
    close_out();
  end
endmodule
`default_nettype wire
